// file: common/vefs_pkg.sv
// Constants and types of the enable, fault and status supervisor
//
// Overview of operation
// R1 - Enable only inside the threshold window
// R2 - Disable level shuts off, clears overcurrent, undervoltage and overvoltage faults, arms
// R3 - Input overcurrent or overvoltage latches catastrophic fault
// R4 - Catastrophic latch clears only by power cycle
// R5 - Ready asserts after soft-start, held in operation
// R6 - Ready drops on any protection fault
// R7 - Over-temperature alert low above configured limit
// R8 - Temperature enable with hysteresis between levels
// R9 - Temperature enable falling sets status bit 2
// R10 - Host clears over-temperature flag after start-up
// R11 - Phase count from first tied-high PWM output
// R12 - Phases fire in order one to N
// R13 - PWM1 tied high disables and releases address
// R14 - Current monitor trip starts overcurrent shutdown
// R15 - Current readback full scale at 2.5V
// R16 - No monitor overcurrent during voltage transition
// R17 - Phase shedding off by grounded pin or bit
// R18 - Bank and boot source from bank strap
// R19 - Bus address and generation from address strap
// R20 - Serial alert driven active low, synchronously to the clock
// R21 - Bank loading finished within maximum load time
// R22 - Protection faults latched until disable or power cycle
package vefs_pkg;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned LOAD_MAX_MS = 20;
	localparam int unsigned LOAD_CYC = LOAD_MAX_MS * 1000 * CLK_MHZ;
	localparam logic [7:0] REG_CLEAR_FAULT = 8'h03;
	localparam logic [7:0] REG_VID_VID_OUTPUT_CURRENT = 8'h15;
	localparam logic [7:0] REG_STATUS = 8'h78;
	localparam logic [7:0] REG_VID_OUTPUT_CURRENT_RB = 8'h8c;
	localparam logic [7:0] REG_SHED_CFG = 8'hd4;
	localparam logic [7:0] REG_TLIM_CFG = 8'he8;
	localparam int unsigned SHED_DIS_BIT = 2;
	localparam int unsigned STAT_OT_BIT = 2;
	localparam int unsigned STAT_OFF_BIT = 6;
	localparam int unsigned STAT_CML_BIT = 1;
	localparam int unsigned STAT_OC_BIT = 4;
	localparam int unsigned STAT_OV_BIT = 5;
	localparam int unsigned STAT_UV_BIT = 3;
	localparam logic [7:0] SHED_CFG_RST = 8'h00;
	localparam logic [7:0] TLIM_CFG_RST = 8'h07;
	localparam logic [7:0] VID_OUTPUT_CURRENT_FULL = 8'hff;
	localparam logic [9:0] CURRENT_MONITOR_OUT_FULL_CODE = 10'h271;
	localparam logic [9:0] CURRENT_MONITOR_OUT_TRIP_CODE = 10'h2ee;
	localparam int unsigned PH_MAX = 6;
	typedef enum logic [2:0] {VEFS_LOAD, VEFS_OFF, VEFS_SOFT, VEFS_RUN, VEFS_FAULT,
		VEFS_DEAD} vefs_state_t;
endpackage

// file: common/vefs_reg_if.sv
// Register access bundle between supervisor core and register file
`timescale 1ns/10ps
`default_nettype none
interface vefs_reg_if;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [15:0] rdata;
	logic [7:0] status;
	logic [9:0] current_monitor_out_code;
	logic [7:0] shed_cfg;
	logic [7:0] tlim_cfg;
	logic clr_fault;
	modport core(output wr, rd, addr, wdata, status, current_monitor_out_code, input rdata, shed_cfg,
		tlim_cfg, clr_fault);
	modport regs(input wr, rd, addr, wdata, status, current_monitor_out_code, output rdata, shed_cfg,
		tlim_cfg, clr_fault);
endinterface
`default_nettype wire

// file: rtl/vefs_regs.sv
// Management register file of the supervisor
`timescale 1ns/10ps
`default_nettype none
module vefs_regs (
	input wire logic clk,
	input wire logic arst_n,
	vefs_reg_if.regs rb
);
	logic [7:0] shed_r;
	logic [7:0] tlim_r;
	logic [15:0] rdata_r;
	logic clr_r;
	logic [17:0] scaled;
	logic [7:0] vid_output_current_code;
	assign rb.shed_cfg = shed_r;
	assign rb.tlim_cfg = tlim_r;
	assign rb.rdata = rdata_r;
	assign rb.clr_fault = clr_r;
	always_comb begin
		scaled = 18'({rb.current_monitor_out_code, 8'h00}) - 18'(rb.current_monitor_out_code);
		if (rb.current_monitor_out_code >= vefs_pkg::CURRENT_MONITOR_OUT_FULL_CODE) begin
			vid_output_current_code = vefs_pkg::VID_OUTPUT_CURRENT_FULL; // [R15]
		end else begin
			vid_output_current_code = 8'(scaled / 18'(vefs_pkg::CURRENT_MONITOR_OUT_FULL_CODE)); // [R15]
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shed_r <= vefs_pkg::SHED_CFG_RST;
			tlim_r <= vefs_pkg::TLIM_CFG_RST;
		end else if (rb.wr) begin
			if (rb.addr == vefs_pkg::REG_SHED_CFG) begin
				shed_r <= rb.wdata;
			end
			if (rb.addr == vefs_pkg::REG_TLIM_CFG) begin
				tlim_r <= rb.wdata;
			end
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clr_r <= 1'b0;
		end else begin
			clr_r <= rb.wr && (rb.addr == vefs_pkg::REG_CLEAR_FAULT); // [R10]
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 16'h0000;
		end else if (rb.rd) begin
			unique case (rb.addr)
				vefs_pkg::REG_VID_VID_OUTPUT_CURRENT: rdata_r <= {8'h00, vid_output_current_code};
				vefs_pkg::REG_STATUS: rdata_r <= {8'h00, rb.status};
				vefs_pkg::REG_VID_OUTPUT_CURRENT_RB: rdata_r <= {8'h00, vid_output_current_code};
				vefs_pkg::REG_SHED_CFG: rdata_r <= {8'h00, shed_r};
				vefs_pkg::REG_TLIM_CFG: rdata_r <= {8'h00, tlim_r};
				default: rdata_r <= 16'h0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: rtl/vefs_supervisor.sv
// Enable, fault and status supervisor top
`timescale 1ns/10ps
`default_nettype none
module vefs_supervisor #(
	parameter int unsigned LOAD_CYCLES = vefs_pkg::LOAD_CYC,
	parameter int unsigned SOFT_CYCLES = 1000,
	parameter int unsigned PHASES = vefs_pkg::PH_MAX
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic en_above_on_low,
	input wire logic en_above_on_high,
	input wire logic en_below_off_low,
	input wire logic en_above_off_high,
	input wire logic temp_en_above_high,
	input wire logic temp_en_below_low,
	input wire logic [2:0] temperature_code,
	input wire logic input_current_sense_trip,
	input wire logic overvoltage_protect_in,
	input wire logic undervoltage_protect_in,
	input wire logic overcurrent_protect_in,
	input wire logic [9:0] current_monitor_out,
	input wire logic dynamic_vid_active,
	input wire logic [5:0] pwm_tied_high,
	input wire logic shed_pin_grounded,
	input wire logic [2:0] bank_boot_strap,
	input wire logic boot_from_strap,
	input wire logic [3:0] address_spec_strap,
	input wire logic serial_alert_req,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic catastrophic_fault,
	output logic regulator_ready_oe,
	output logic overtemp_alert_n_oe,
	output logic serial_alert_n_oe,
	output logic regulator_on,
	output logic [2:0] phase_count,
	output logic [PHASES-1:0] phase_fire,
	output logic shed_enable,
	output logic [2:0] bank_select,
	output logic boot_strap_sel,
	output logic [2:0] bus_address,
	output logic spec_generation,
	output logic address_released,
	output logic config_done
);
	if (PHASES < 2 || PHASES > 6 || SOFT_CYCLES < 1 || LOAD_CYCLES < 1) begin : g_bad_param
		$error("vefs_supervisor: unsupported parameter");
	end
	localparam int unsigned NIN = 27;
	logic [NIN-1:0] raw;
	logic [NIN-1:0] s1_r;
	logic [NIN-1:0] s2_r;
	logic [9:0] imon1_r;
	logic [9:0] imon2_r;
	logic [2:0] tc1_r;
	logic [2:0] tc2_r;
	assign raw = {en_above_on_low, en_above_on_high, en_below_off_low, en_above_off_high,
		temp_en_above_high, temp_en_below_low, input_current_sense_trip,
		overvoltage_protect_in, undervoltage_protect_in, overcurrent_protect_in,
		dynamic_vid_active, serial_alert_req, shed_pin_grounded, pwm_tied_high,
		bank_boot_strap, boot_from_strap, address_spec_strap};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			imon1_r <= '0;
			imon2_r <= '0;
			tc1_r <= '0;
			tc2_r <= '0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			imon1_r <= current_monitor_out;
			imon2_r <= imon1_r;
			tc1_r <= temperature_code;
			tc2_r <= tc1_r;
		end
	end
	logic on_lo;
	logic on_hi;
	logic off_lo;
	logic off_hi;
	logic t_hi;
	logic t_lo;
	logic in_oc;
	logic ov;
	logic uv;
	logic oc;
	logic dvid;
	logic alert_req;
	logic shed_gnd;
	logic [5:0] pw_tied;
	logic [2:0] bank_s;
	logic boot_s;
	logic [3:0] addr_s;
	assign {on_lo, on_hi, off_lo, off_hi, t_hi, t_lo, in_oc, ov, uv, oc, dvid, alert_req, shed_gnd,
		pw_tied, bank_s, boot_s, addr_s} = s2_r;
	vefs_reg_if rb();
	assign rb.wr = reg_wr;
	assign rb.rd = reg_rd;
	assign rb.addr = reg_addr;
	assign rb.wdata = reg_wdata;
	assign rb.current_monitor_out_code = imon2_r;
	vefs_regs u_regs (
		.clk(clk),
		.arst_n(arst_n),
		.rb(rb)
	);
	assign reg_rdata = rb.rdata;
	logic en_window;
	logic en_kill;
	assign en_window = on_lo && !on_hi; // [R1]
	assign en_kill = off_lo || off_hi; // [R2]
	logic temp_en_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			temp_en_r <= 1'b0;
		end else if (t_hi) begin
			temp_en_r <= 1'b1; // [R8]
		end else if (t_lo) begin
			temp_en_r <= 1'b0; // [R8]
		end
	end
	logic cat_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cat_r <= 1'b0; // [R4]
		end else if (in_oc || ov) begin
			cat_r <= 1'b1; // [R3]
		end
	end
	logic disabled;
	assign disabled = address_released;
	vefs_pkg::vefs_state_t st_r;
	logic [31:0] cnt_r;
	logic current_monitor_out_trip;
	assign current_monitor_out_trip = (imon2_r >= vefs_pkg::CURRENT_MONITOR_OUT_TRIP_CODE) && !dvid; // [R14] [R16]
	logic oc_r;
	logic uv_r;
	logic ov_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			oc_r <= 1'b0;
			uv_r <= 1'b0;
			ov_r <= 1'b0;
		end else if (en_kill) begin
			oc_r <= 1'b0; // [R2] [R22]
			uv_r <= 1'b0;
			ov_r <= 1'b0;
		end else if (st_r == vefs_pkg::VEFS_SOFT || st_r == vefs_pkg::VEFS_RUN) begin
			oc_r <= oc_r || oc || current_monitor_out_trip; // [R22] [R14]
			uv_r <= uv_r || uv; // [R22]
			ov_r <= ov_r || ov; // [R22]
		end
	end
	logic any_fault;
	assign any_fault = oc_r || uv_r || ov_r || cat_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= vefs_pkg::VEFS_LOAD;
			cnt_r <= '0;
		end else begin
			unique case (st_r)
				vefs_pkg::VEFS_LOAD: begin
					if (cnt_r >= LOAD_CYCLES - 1) begin
						cnt_r <= '0;
						st_r <= disabled ? vefs_pkg::VEFS_DEAD : vefs_pkg::VEFS_OFF; // [R21] [R13]
					end else begin
						cnt_r <= cnt_r + 32'h1; // [R21]
					end
				end
				vefs_pkg::VEFS_OFF: begin
					cnt_r <= '0; // [R2]
					if (en_window && !en_kill && temp_en_r && !any_fault) begin
						st_r <= vefs_pkg::VEFS_SOFT; // [R1]
					end
				end
				vefs_pkg::VEFS_SOFT, vefs_pkg::VEFS_RUN: begin
					if (en_kill || !temp_en_r) begin
						st_r <= vefs_pkg::VEFS_OFF; // [R2] [R8]
					end else if (any_fault) begin
						st_r <= vefs_pkg::VEFS_FAULT; // [R6]
					end else if (st_r == vefs_pkg::VEFS_SOFT) begin
						if (cnt_r >= SOFT_CYCLES - 1) begin
							st_r <= vefs_pkg::VEFS_RUN;
						end else begin
							cnt_r <= cnt_r + 32'h1;
						end
					end
				end
				vefs_pkg::VEFS_FAULT: begin
					if (en_kill) begin
						st_r <= vefs_pkg::VEFS_OFF; // [R22]
					end
				end
				vefs_pkg::VEFS_DEAD: st_r <= vefs_pkg::VEFS_DEAD; // [R13]
				default: st_r <= vefs_pkg::VEFS_OFF;
			endcase
		end
	end
	logic otf_r;
	logic temp_en_d_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			otf_r <= 1'b0;
			temp_en_d_r <= 1'b0;
		end else begin
			temp_en_d_r <= temp_en_r;
			if (temp_en_d_r && !temp_en_r) begin
				otf_r <= 1'b1; // [R9]
			end else if (rb.clr_fault) begin
				otf_r <= 1'b0; // [R10]
			end
		end
	end
	assign rb.status = (8'(otf_r) << vefs_pkg::STAT_OT_BIT)
		| (8'(st_r != vefs_pkg::VEFS_RUN) << vefs_pkg::STAT_OFF_BIT)
		| (8'(oc_r) << vefs_pkg::STAT_OC_BIT)
		| (8'(ov_r) << vefs_pkg::STAT_OV_BIT)
		| (8'(uv_r) << vefs_pkg::STAT_UV_BIT)
		| (8'(cat_r) << vefs_pkg::STAT_CML_BIT);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			catastrophic_fault <= 1'b0;
			regulator_ready_oe <= 1'b1;
			overtemp_alert_n_oe <= 1'b0;
			serial_alert_n_oe <= 1'b0;
			regulator_on <= 1'b0;
			shed_enable <= 1'b0;
		end else begin
			catastrophic_fault <= cat_r; // [R3]
			regulator_ready_oe <= !(st_r == vefs_pkg::VEFS_RUN && !any_fault); // [R5] [R6]
			overtemp_alert_n_oe <= tc2_r > rb.tlim_cfg[2:0]; // [R7]
			serial_alert_n_oe <= alert_req && !disabled; // [R20]
			regulator_on <= st_r == vefs_pkg::VEFS_SOFT || st_r == vefs_pkg::VEFS_RUN;
			shed_enable <= !shed_gnd
				&& !rb.shed_cfg[vefs_pkg::SHED_DIS_BIT]; // [R17]
		end
	end
	logic [2:0] pc_nxt;
	always_comb begin
		pc_nxt = 3'(PHASES);
		for (int i = PHASES - 1; i >= 1; i--) begin
			if (pw_tied[i]) begin
				pc_nxt = 3'(i); // [R11]
			end
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_count <= 3'h0;
			address_released <= 1'b0;
			bank_select <= 3'h0;
			boot_strap_sel <= 1'b0;
			bus_address <= 3'h0;
			spec_generation <= 1'b0;
			config_done <= 1'b0;
		end else if (st_r == vefs_pkg::VEFS_LOAD) begin
			phase_count <= pc_nxt; // [R11]
			address_released <= pw_tied[0]; // [R13]
			bank_select <= bank_s; // [R18]
			boot_strap_sel <= boot_s; // [R18]
			bus_address <= addr_s[2:0]; // [R19]
			spec_generation <= addr_s[3]; // [R19]
		end else begin
			config_done <= 1'b1; // [R21]
		end
	end
	logic [2:0] ph_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ph_r <= 3'h0;
			phase_fire <= '0;
		end else if (st_r == vefs_pkg::VEFS_SOFT || st_r == vefs_pkg::VEFS_RUN) begin
			ph_r <= (ph_r + 3'h1 >= phase_count) ? 3'h0 : ph_r + 3'h1; // [R12]
			phase_fire <= PHASES'(1) << ph_r; // [R12]
		end else begin
			ph_r <= 3'h0;
			phase_fire <= '0;
		end
	end
endmodule
`default_nettype wire

// file: tb/vefs_monitor.sv
// Port checker of the supervisor
`timescale 1ns/10ps
`default_nettype none
module vefs_monitor #(
	parameter int unsigned LOAD_CYCLES = 20,
	parameter int unsigned PHASES = 6
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic en_below_off_low,
	input wire logic input_current_sense_trip,
	input wire logic [9:0] current_monitor_out,
	input wire logic dynamic_vid_active,
	input wire logic serial_alert_req,
	input wire logic catastrophic_fault,
	input wire logic regulator_ready_oe,
	input wire logic serial_alert_n_oe,
	input wire logic regulator_on,
	input wire logic [2:0] phase_count,
	input wire logic [PHASES-1:0] phase_fire,
	input wire logic address_released,
	input wire logic config_done
);
	int unsigned cyc_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc_r <= 0;
		end else if (cyc_r < 1000) begin
			cyc_r <= cyc_r + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_trip;
		(current_monitor_out >= vefs_pkg::CURRENT_MONITOR_OUT_TRIP_CODE && !dynamic_vid_active && regulator_on)[*4];
	endsequence
	sequence s_off;
		en_below_off_low[*4];
	endsequence
	a_cfp_latch: assert property (catastrophic_fault |=> catastrophic_fault)
		else $error("fault latch dropped");
	a_cfp_set: assert property (config_done && input_current_sense_trip |-> ##[1:4] catastrophic_fault)
		else $error("fault latch not set");
	a_rdy_fault: assert property (catastrophic_fault |-> ##[0:2] regulator_ready_oe)
		else $error("ready kept with fault");
	a_ready_run: assert property ($fell(regulator_ready_oe) |-> regulator_on)
		else $error("ready while not running");
	a_dead_off: assert property (config_done && address_released |-> !regulator_on)
		else $error("runs with address released");
	a_trip_shut: assert property (s_trip |-> ##[0:3] regulator_ready_oe)
		else $error("no trip shutdown");
	a_off_level: assert property (s_off |-> ##[0:3] !regulator_on)
		else $error("no shutdown on disable");
	a_fire_order: assert property (regulator_on && phase_fire != 0 && !phase_fire[phase_count - 1]
		|=> !regulator_on || phase_fire == $past(phase_fire) << 1)
		else $error("phase order broken");
	a_load_time: assert property (cyc_r == LOAD_CYCLES + 6 |-> config_done)
		else $error("load too slow");
	a_alert_drive: assert property (config_done && !address_released && serial_alert_req
		|-> ##[1:4] serial_alert_n_oe)
		else $error("alert not driven");
endmodule
bind vefs_supervisor vefs_monitor #(.LOAD_CYCLES(LOAD_CYCLES), .PHASES(PHASES)) u_mon (.clk(clk),
	.arst_n(arst_n), .en_below_off_low(en_below_off_low),
	.input_current_sense_trip(input_current_sense_trip), .current_monitor_out(current_monitor_out),
	.dynamic_vid_active(dynamic_vid_active), .serial_alert_req(serial_alert_req),
	.catastrophic_fault(catastrophic_fault), .regulator_ready_oe(regulator_ready_oe),
	.serial_alert_n_oe(serial_alert_n_oe), .regulator_on(regulator_on),
	.phase_count(phase_count), .phase_fire(phase_fire), .address_released(address_released),
	.config_done(config_done));
`default_nettype wire

// file: tb/vefs_host.sv
// Management host model on the register port
`timescale 1ns/10ps
`default_nettype none
module vefs_host (
	input wire logic clk,
	input wire logic [15:0] reg_rdata,
	output logic reg_wr = 0,
	output logic reg_rd = 0,
	output logic [7:0] reg_addr = 0,
	output logic [7:0] reg_wdata = 0
);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge clk);
		#1;
		reg_wr = 0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] q);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1;
		@(posedge clk);
		#1;
		q = reg_rdata;
		reg_rd = 0;
		reg_addr = ~a;
	endtask
	task automatic clear();
		wr(vefs_pkg::REG_CLEAR_FAULT, 8'h00);
	endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, e, s); end end
module tb;
	logic clk = 0, arst_n = 0, en_above_on_low = 0, en_above_on_high = 0, en_below_off_low = 0;
	logic en_above_off_high = 0, temp_en_above_high = 0, temp_en_below_low = 1;
	logic input_current_sense_trip = 0, overvoltage_protect_in = 0, undervoltage_protect_in = 0;
	logic overcurrent_protect_in = 0, dynamic_vid_active = 0, shed_pin_grounded = 0;
	logic boot_from_strap = 0, serial_alert_req = 0;
	logic [2:0] temperature_code = 0, bank_boot_strap = 0, lim;
	logic [9:0] current_monitor_out = 0;
	logic [5:0] pwm_tied_high = 0, phase_fire;
	logic [3:0] address_spec_strap = 0;
	logic reg_wr, reg_rd, catastrophic_fault, regulator_ready_oe, overtemp_alert_n_oe;
	logic serial_alert_n_oe, regulator_on, shed_enable, boot_strap_sel, spec_generation;
	logic address_released, config_done;
	logic [7:0] reg_addr, reg_wdata;
	logic [15:0] reg_rdata, q;
	logic [2:0] phase_count, bank_select, bus_address;
	int n_mismatch = 0, cmp_count = 0;
	always #4 clk = ~clk;
	vefs_supervisor #(.LOAD_CYCLES(20), .SOFT_CYCLES(10)) i_dut (.clk, .arst_n, .en_above_on_low,
		.en_above_on_high, .en_below_off_low, .en_above_off_high, .temp_en_above_high,
		.temp_en_below_low, .temperature_code, .input_current_sense_trip, .overvoltage_protect_in,
		.undervoltage_protect_in, .overcurrent_protect_in, .current_monitor_out, .dynamic_vid_active,
		.pwm_tied_high, .shed_pin_grounded, .bank_boot_strap, .boot_from_strap, .address_spec_strap,
		.serial_alert_req, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .catastrophic_fault,
		.regulator_ready_oe, .overtemp_alert_n_oe, .serial_alert_n_oe, .regulator_on, .phase_count,
		.phase_fire, .shed_enable, .bank_select, .boot_strap_sel, .bus_address, .spec_generation,
		.address_released, .config_done);
	vefs_host i_host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
	function automatic int exp_ph(input logic [5:0] pw);
		for (int i = 1; i < 6; i++) if (pw[i]) return i;
		return 6;
	endfunction
	task automatic results();
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic boot(input logic [5:0] pw, input logic sg);
		tick(1);
		arst_n = 0;
		pwm_tied_high = pw;
		shed_pin_grounded = sg;
		bank_boot_strap = 3'($urandom_range(7));
		address_spec_strap = 4'($urandom_range(15));
		boot_from_strap = 1'($urandom_range(1));
		tick(3);
		arst_n = 1;
		for (int i = 0; i < 60 && config_done !== 1'b1; i++) tick(1);
		`CHK("phases", 3'(exp_ph(pw)), phase_count)
		`CHK("released", pw[0], address_released)
		`CHK("address", address_spec_strap[2:0], bus_address)
		`CHK("generation", address_spec_strap[3], spec_generation)
		`CHK("bank", bank_boot_strap, bank_select)
		`CHK("boot source", boot_from_strap, boot_strap_sel)
		`CHK("shed", !sg, shed_enable)
	endtask
	task automatic start();
		en_below_off_low = 0;
		en_above_on_low = 1;
		temp_en_below_low = 0;
		temp_en_above_high = 1;
		for (int i = 0; i < 60 && regulator_ready_oe !== 1'b0; i++) tick(1);
	endtask
	initial begin
		void'($urandom(32'haba930c5));
		boot(6'h01, 0);
		start();
		`CHK("dead on", 1'b0, regulator_on)
		boot(6'h00, 1);
		boot(6'h01 << $urandom_range(5, 1), 0);
		i_host.rd(vefs_pkg::REG_TLIM_CFG, q);
		`CHK("limit reset", {8'h00, vefs_pkg::TLIM_CFG_RST}, q)
		i_host.rd(8'h40, q);
		`CHK("unmapped", 16'h0000, q)
		i_host.wr(vefs_pkg::REG_SHED_CFG, 8'h04);
		tick(3);
		`CHK("shed bit", 1'b0, shed_enable)
		en_below_off_low = 1;
		en_above_on_low = 0;
		tick(6);
		en_below_off_low = 0;
		en_above_on_low = 1;
		en_above_on_high = 1;
		temp_en_below_low = 0;
		temp_en_above_high = 1;
		tick(20);
		`CHK("above window", 1'b0, regulator_on)
		en_above_on_high = 0;
		start();
		`CHK("run", 1'b1, regulator_on)
		serial_alert_req = 1;
		tick(5);
		`CHK("alert", 1'b1, serial_alert_n_oe)
		serial_alert_req = 0;
		lim = 3'($urandom_range(6));
		i_host.wr(vefs_pkg::REG_TLIM_CFG, {5'h00, lim});
		temperature_code = lim + 3'h1;
		tick(5);
		`CHK("hot", 1'b1, overtemp_alert_n_oe)
		temperature_code = lim;
		tick(5);
		`CHK("not hot", 1'b0, overtemp_alert_n_oe)
		temp_en_above_high = 0;
		temp_en_below_low = 1;
		tick(6);
		temp_en_below_low = 0;
		tick(6);
		`CHK("temp off", 1'b0, regulator_on)
		i_host.rd(vefs_pkg::REG_STATUS, q);
		`CHK("ot flag", 1'b1, q[2])
		start();
		i_host.clear();
		tick(3);
		i_host.rd(vefs_pkg::REG_STATUS, q);
		`CHK("ot cleared", 1'b0, q[2])
		dynamic_vid_active = 1;
		current_monitor_out = 10'($urandom_range(1023, 750));
		tick(12);
		`CHK("dvid hold", 1'b0, regulator_ready_oe)
		dynamic_vid_active = 0;
		tick(6);
		current_monitor_out = vefs_pkg::CURRENT_MONITOR_OUT_FULL_CODE;
		tick(6);
		i_host.rd(vefs_pkg::REG_STATUS, q);
		`CHK("oc latched", 1'b1, q[4])
		i_host.rd(vefs_pkg::REG_VID_OUTPUT_CURRENT_RB, q);
		`CHK("readback", 16'h00ff, q)
		i_host.rd(vefs_pkg::REG_VID_VID_OUTPUT_CURRENT, q);
		`CHK("vid current", vefs_pkg::VID_OUTPUT_CURRENT_FULL, q[7:0])
		en_below_off_low = 1;
		en_above_on_low = 0;
		tick(6);
		i_host.rd(vefs_pkg::REG_STATUS, q);
		`CHK("oc cleared", 1'b0, q[4])
		start();
		input_current_sense_trip = 1;
		tick(3);
		input_current_sense_trip = 0;
		en_below_off_low = 1;
		temp_en_below_low = 1;
		tick(6);
		start();
		`CHK("latch kept", 1'b1, catastrophic_fault)
		`CHK("ready low", 1'b1, regulator_ready_oe)
		results();
	end
	initial begin
		#40000;
		n_mismatch++;
		results();
	end
endmodule
`default_nettype wire
